// ==== verilog/gup_pkg.sv ====
// Constants for the eight-pin utility port: register indices, field positions,
// reset values and the auto-toggle timing.
// Assumes a 100 MHz aclk and a word-per-register AXI4-Lite map.
package gup_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_PIN_DIRECTION   = 8'h97;
	localparam logic [7:0] IDX_PIN_OUTPUT_DATA = 8'h9A;
	localparam logic [7:0] IDX_PIN_INPUT_DATA  = 8'h9B;
	localparam logic [7:0] IDX_PIN_CHANGE_MASK = 8'h9C;
	localparam logic [7:0] IDX_UTILITY_SETUP   = 8'h9D;
	localparam logic [7:0] IDX_PIN_CHANGE_FLAGS = 8'hC0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PIN_DIRECTION   = 8'h00;
	localparam logic [7:0] RST_PIN_OUTPUT_DATA = 8'h00;
	localparam logic [7:0] RST_PIN_CHANGE_MASK = 8'hFF;
	localparam logic [7:0] RST_UTILITY_SETUP   = 8'h00;
	localparam logic [7:0] RST_PIN_CHANGE_FLAGS = 8'h00;

	// ==========================================================
	// Utility setup fields
	localparam int SCRATCH_MEM_MAP_SELECT_BIT     = 7;
	localparam int UTIL_RESERVED_BIT              = 6;
	localparam int PIN0_AUTO_TOGGLE_ENABLE_BIT    = 5;
	localparam int PIN4_WRITE_STROBE_SELECT_BIT   = 4;
	localparam int PIN3_TIMER1_TRIGGER_SELECT_BIT = 3;
	localparam int PIN2_TIMER0_TRIGGER_SELECT_BIT = 2;
	localparam int PIN1_SERIAL_TX_SELECT_BIT      = 1;
	localparam int PIN0_SERIAL_RX_SELECT_BIT      = 0;

	// ==========================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS      = 10;
	localparam int TOGGLE_PERIOD_NS   = 1000000000;
	localparam int TOGGLE_HALF_CYCLES = TOGGLE_PERIOD_NS / CLK_PERIOD_NS / 2;

endpackage

// ==== verilog/gup_toggle_gen.sv ====
// Square wave source for the pin 0 auto-toggle.
// Assumes aclk and a synchronous active-low reset shared with the port.
`timescale 1ns/1ps
module gup_toggle_gen
	import gup_pkg::*;
#(
	parameter int HALF_CYCLES = TOGGLE_HALF_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic enable,
	output logic      level
);

	localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

	if (HALF_CYCLES < 1) begin : g_check_half
		$error("HALF_CYCLES must be at least 1");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          level;
	} gup_tog_state_t;

	gup_tog_state_t st_r;
	gup_tog_state_t st_nxt;

	// ==========================================================
	// Half period counter
	always_comb begin
		st_nxt = st_r;
		if (!enable) begin
			// Restart from low so each enable gives a full first half
			st_nxt.cnt   = '0;
			st_nxt.level = 1'b0;
		end else if (st_r.cnt == LAST) begin
			st_nxt.cnt   = '0;
			st_nxt.level = ~st_r.level;
		end else begin
			st_nxt.cnt = st_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign level = st_r.level;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_toggle_idle_low: assert property (!enable |=> !level)
		else $error("toggle level not low while disabled");
	a_toggle_half_edge: assert property ((enable && st_r.cnt == LAST) |=>
		(level != $past(level)))
		else $error("toggle level did not flip at half period");
	a_toggle_steady: assert property ((enable && st_r.cnt != LAST) |=>
		(level == $past(level)))
		else $error("toggle level flipped before half period");

endmodule

// ==== verilog/gup_utility_port.sv ====
// Eight-pin utility port with change flags, pin muxing and auto-toggle,
// reached over AXI4-Lite.
// Assumes pins, strobe and serial inputs are synchronous to aclk.
//
// Function
// - Output data bit drives the pin buffer.
// - Input data register reads current pin levels.
// - Any pin level change sets its flag.
// - Writing 1 clears flag; 0 no effect.
// - Interrupt high while unmasked flag set.
// - Mask bit 1 blocks that flag's interrupt.
// - Select bit maps scratch SRAM code/data.
// - Toggle enable auto-toggles output pin 0.
// - Toggle period one second, half duty.
// - Bit 4 routes write strobe to pin 4.
// - Bit 3 clear: timer 1 from pin 3.
// - Bit 2 clear: timer 0 from pin 2.
// - Bit 1 routes serial transmit to pin 1.
// - Bit 0 ties serial receive to zero.
`timescale 1ns/1ps
module gup_utility_port
	import gup_pkg::*;
#(
	parameter int ADDR_W      = 10,
	parameter int HALF_CYCLES = TOGGLE_HALF_CYCLES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [7:0]        pin_in,
	output logic [7:0]             pin_out,
	output logic [7:0]             pin_oe,
	input  wire logic              disk_io_write_strobe,
	input  wire logic              processor_port3_bit1,
	output logic                   processor_port3_bit0,
	output logic                   timer0_trigger,
	output logic                   timer1_trigger,
	output logic                   processor_ext_irq_line,
	output logic                   scratch_in_code_space,
	output logic                   scratch_in_data_space
);

	if (ADDR_W < 10) begin : g_check_addr
		$error("ADDR_W must be at least 10 to reach every register");
	end
	if (HALF_CYCLES < 1) begin : g_check_half
		$error("HALF_CYCLES must be at least 1");
	end

	typedef struct packed {
		logic [7:0]        dir;
		logic [7:0]        odata;
		logic [7:0]        mask;
		logic [7:0]        util;
		logic [7:0]        flags;
		logic [7:0]        pin_prev;
		logic              primed;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] waddr;
		logic [7:0]        wbyte;
		logic              wlane0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [7:0]        rbyte;
		logic [7:0]        pin_out;
		logic [7:0]        pin_oe;
		logic              rx;
		logic              t0;
		logic              t1;
		logic              irq;
		logic              code_map;
		logic              data_map;
	} gup_state_t;

	localparam gup_state_t ST_RESET = '{
		dir:      RST_PIN_DIRECTION,
		odata:    RST_PIN_OUTPUT_DATA,
		mask:     RST_PIN_CHANGE_MASK,
		util:     RST_UTILITY_SETUP,
		flags:    RST_PIN_CHANGE_FLAGS,
		data_map: !RST_UTILITY_SETUP[SCRATCH_MEM_MAP_SELECT_BIT],
		default:  '0
	};

	gup_state_t st_r;
	gup_state_t st_nxt;
	logic       tog_level;
	logic       wr_fire;
	logic [8:0] wr_dec;
	logic [8:0] rd_dec;
	logic [7:0] change;
	logic [7:0] clr_mask;

	// ==========================================================
	// Address decode
	// Returns {hit, index}; misaligned or out-of-range addresses miss
	function automatic logic [8:0] decode(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		logic       ok;
		idx = addr[9:2];
		ok  = (addr[1:0] == 2'h0) && ((addr >> 10) == '0);
		case (idx)
			IDX_PIN_DIRECTION, IDX_PIN_OUTPUT_DATA, IDX_PIN_INPUT_DATA,
			IDX_PIN_CHANGE_MASK, IDX_UTILITY_SETUP, IDX_PIN_CHANGE_FLAGS: ;
			default: ok = 1'b0;
		endcase
		return {ok, idx};
	endfunction

	assign wr_dec  = decode(st_r.waddr);
	assign rd_dec  = decode(araddr);
	assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
	// Change detection waits one cycle after reset for a valid history
	assign change  = st_r.primed ? (pin_in ^ st_r.pin_prev) : 8'h00;
	assign clr_mask = (wr_fire && wr_dec[8] && st_r.wlane0 &&
		wr_dec[7:0] == IDX_PIN_CHANGE_FLAGS) ? st_r.wbyte : 8'h00;

	gup_toggle_gen #(
		.HALF_CYCLES (HALF_CYCLES)
	) u_toggle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.enable  (st_r.util[PIN0_AUTO_TOGGLE_ENABLE_BIT] && st_r.dir[0]),
		.level   (tog_level)
	);

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt          = st_r;
		st_nxt.primed   = 1'b1;
		st_nxt.pin_prev = pin_in;

		// Address and data are taken independently, in either order
		if (awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.waddr  = awaddr;
		end
		if (wvalid && st_r.wready) begin
			st_nxt.w_got  = 1'b1;
			st_nxt.wbyte  = wdata[7:0];
			st_nxt.wlane0 = wstrb[0];
		end

		if (wr_fire) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = wr_dec[8] ? RESP_OKAY : RESP_SLVERR;
			// Only lane 0 carries register bits; the input register ignores writes
			if (wr_dec[8] && st_r.wlane0) begin
				unique case (wr_dec[7:0])
					IDX_PIN_DIRECTION:   st_nxt.dir   = st_r.wbyte;
					IDX_PIN_OUTPUT_DATA: st_nxt.odata = st_r.wbyte;
					IDX_PIN_CHANGE_MASK: st_nxt.mask  = st_r.wbyte;
					// Bit 6 is stored as written; software keeps it at zero
					IDX_UTILITY_SETUP:   st_nxt.util  = st_r.wbyte;
					default: ;
				endcase
			end
		end else if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Set wins over clear when both land in one cycle
		st_nxt.flags = (st_r.flags & ~clr_mask) | change;

		if (arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
			st_nxt.rbyte  = 8'h00;
			if (rd_dec[8]) begin
				unique case (rd_dec[7:0])
					IDX_PIN_DIRECTION:    st_nxt.rbyte = st_r.dir;
					IDX_PIN_OUTPUT_DATA:  st_nxt.rbyte = st_r.odata;
					IDX_PIN_INPUT_DATA:   st_nxt.rbyte = pin_in;
					IDX_PIN_CHANGE_MASK:  st_nxt.rbyte = st_r.mask;
					IDX_UTILITY_SETUP:    st_nxt.rbyte = st_r.util;
					IDX_PIN_CHANGE_FLAGS: st_nxt.rbyte = st_r.flags;
					default: ;
				endcase
			end
		end else if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// One write and one read in flight at most
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;

		// Pin drivers and alternate functions
		st_nxt.pin_oe  = st_nxt.dir;
		st_nxt.pin_out = st_nxt.odata;
		if (st_nxt.util[PIN0_AUTO_TOGGLE_ENABLE_BIT] && st_nxt.dir[0])
			st_nxt.pin_out[0] = tog_level;
		if (st_nxt.util[PIN1_SERIAL_TX_SELECT_BIT]) begin
			st_nxt.pin_out[1] = processor_port3_bit1;
			st_nxt.pin_oe[1]  = 1'b1;
		end
		if (st_nxt.util[PIN4_WRITE_STROBE_SELECT_BIT]) begin
			st_nxt.pin_out[4] = disk_io_write_strobe;
			st_nxt.pin_oe[4]  = 1'b1;
		end
		// Alternate trigger sources are undefined, so they read as zero
		st_nxt.t1 = st_nxt.util[PIN3_TIMER1_TRIGGER_SELECT_BIT] ? 1'b0 : pin_in[3];
		st_nxt.t0 = st_nxt.util[PIN2_TIMER0_TRIGGER_SELECT_BIT] ? 1'b0 : pin_in[2];
		st_nxt.rx = st_nxt.util[PIN0_SERIAL_RX_SELECT_BIT] ? 1'b0 : pin_in[0];
		st_nxt.code_map = st_nxt.util[SCRATCH_MEM_MAP_SELECT_BIT];
		st_nxt.data_map = !st_nxt.util[SCRATCH_MEM_MAP_SELECT_BIT];
		st_nxt.irq = |(st_nxt.flags & ~st_nxt.mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_r <= ST_RESET;
		else
			st_r <= st_nxt;
	end

	// ==========================================================
	// Outputs
	assign awready                = st_r.awready;
	assign wready                 = st_r.wready;
	assign bvalid                 = st_r.bvalid;
	assign bresp                  = st_r.bresp;
	assign arready                = st_r.arready;
	assign rvalid                 = st_r.rvalid;
	assign rresp                  = st_r.rresp;
	assign rdata                  = {24'h000000, st_r.rbyte};
	assign pin_out                = st_r.pin_out;
	assign pin_oe                 = st_r.pin_oe;
	assign processor_port3_bit0   = st_r.rx;
	assign timer0_trigger         = st_r.t0;
	assign timer1_trigger         = st_r.t1;
	assign processor_ext_irq_line = st_r.irq;
	assign scratch_in_code_space  = st_r.code_map;
	assign scratch_in_data_space  = st_r.data_map;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_dir_write_oe: assert property ((wr_fire && wr_dec[8] && st_r.wlane0 &&
		wr_dec[7:0] == IDX_PIN_DIRECTION && st_r.util[4] == 1'b0 && st_r.util[1] == 1'b0)
		|=> (pin_oe == $past(st_r.wbyte)))
		else $error("pin enables do not follow direction write");
	a_out_write_pins: assert property ((wr_fire && wr_dec[8] && st_r.wlane0 &&
		wr_dec[7:0] == IDX_PIN_OUTPUT_DATA)
		|=> (pin_out[7:5] == $past(st_r.wbyte[7:5]) && pin_out[3:2] == $past(st_r.wbyte[3:2])))
		else $error("pins do not follow output data write");
	a_input_read_level: assert property ((arvalid && arready && rd_dec[8] &&
		rd_dec[7:0] == IDX_PIN_INPUT_DATA) |=> (rvalid && rdata[7:0] == $past(pin_in)))
		else $error("input read does not return pin levels");
	a_change_sets_flag: assert property ((st_r.primed && pin_in != st_r.pin_prev) |=>
		((st_r.flags & $past(pin_in ^ st_r.pin_prev)) == $past(pin_in ^ st_r.pin_prev)))
		else $error("level change did not set its flag");
	a_w1c_clears_flag: assert property ((clr_mask != 8'h00 && change == 8'h00) |=>
		((st_r.flags & $past(clr_mask)) == 8'h00 &&
		(st_r.flags | $past(clr_mask)) == ($past(st_r.flags) | $past(clr_mask))))
		else $error("flag clear by one wrong");
	a_irq_unmasked: assert property ((|(st_r.flags & ~st_r.mask)) |-> processor_ext_irq_line)
		else $error("unmasked flag without interrupt");
	a_irq_all_masked: assert property ((st_r.mask == 8'hFF) |-> !processor_ext_irq_line)
		else $error("interrupt while all flags masked");
	a_toggle_pin0: assert property ((st_r.util[5] && st_r.dir[0] && !wr_fire) |=>
		(pin_out[0] == $past(tog_level)))
		else $error("pin 0 does not follow toggle source");
	a_strobe_pin4: assert property ((st_r.util[4] && !wr_fire) |=>
		(pin_out[4] == $past(disk_io_write_strobe) && pin_oe[4]))
		else $error("pin 4 does not carry write strobe");
	a_serial_tx_pin1: assert property ((st_r.util[1] && !wr_fire) |=>
		(pin_out[1] == $past(processor_port3_bit1) && pin_oe[1]))
		else $error("pin 1 does not carry serial transmit");
	a_serial_rx_zero: assert property ((st_r.util[0] && !wr_fire) |=>
		!processor_port3_bit0)
		else $error("serial receive not tied low");
	// The release edge still shows reset values, so it is skipped
	a_timer_sources: assert property (($past(aresetn) && st_r.util[3:2] == 2'b00 &&
		!wr_fire) |=> (timer1_trigger == $past(pin_in[3]) && timer0_trigger == $past(pin_in[2])))
		else $error("timer triggers do not follow pins");
	a_scratch_map: assert property (scratch_in_code_space != scratch_in_data_space)
		else $error("scratch map selects disagree");
	a_scratch_follow: assert property (!wr_fire |=>
		(scratch_in_code_space == $past(st_r.util[SCRATCH_MEM_MAP_SELECT_BIT])))
		else $error("scratch map does not follow select bit");
	a_rx_from_pin0: assert property (($past(aresetn) && !st_r.util[0] && !wr_fire) |=>
		(processor_port3_bit0 == $past(pin_in[0])))
		else $error("serial receive does not follow pin 0");
	a_timer1_alt_zero: assert property ((st_r.util[3] && !wr_fire) |=> !timer1_trigger)
		else $error("timer 1 trigger not held low");
	a_timer0_alt_zero: assert property ((st_r.util[2] && !wr_fire) |=> !timer0_trigger)
		else $error("timer 0 trigger not held low");
	a_pin4_plain: assert property ((!st_r.util[4] && !wr_fire) |=>
		(pin_out[4] == $past(st_r.odata[4]) && pin_oe[4] == $past(st_r.dir[4])))
		else $error("pin 4 does not act as plain pin");
	a_pin1_plain: assert property ((!st_r.util[1] && !wr_fire) |=>
		(pin_out[1] == $past(st_r.odata[1]) && pin_oe[1] == $past(st_r.dir[1])))
		else $error("pin 1 does not act as plain pin");
	a_pin0_plain: assert property ((!(st_r.util[5] && st_r.dir[0]) && !wr_fire) |=>
		(pin_out[0] == $past(st_r.odata[0])))
		else $error("pin 0 does not follow output data");
	a_oe_plain_pins: assert property (!wr_fire |=>
		(pin_oe[7:5] == $past(st_r.dir[7:5]) && pin_oe[3:2] == $past(st_r.dir[3:2]) &&
		pin_oe[0] == $past(st_r.dir[0])))
		else $error("pin enables do not follow direction");
	a_reset_inputs: assert property (!$past(aresetn) |-> (pin_oe == 8'h00 && pin_out == 8'h00))
		else $error("pins not released after reset");
	a_irq_on_change: assert property ((|(change & ~st_r.mask) && !wr_fire) |=>
		processor_ext_irq_line)
		else $error("unmasked change did not raise interrupt");
	a_input_read_only: assert property ((wr_fire && wr_dec[7:0] == IDX_PIN_INPUT_DATA) |=>
		($stable(st_r.dir) && $stable(st_r.odata) && $stable(st_r.mask) && $stable(st_r.util)))
		else $error("write to input register changed state");
	a_w1c_zero_keeps: assert property ((wr_fire && wr_dec[7:0] == IDX_PIN_CHANGE_FLAGS) |=>
		((st_r.flags & ~$past(st_r.wbyte)) ==
		(($past(st_r.flags) | $past(change)) & ~$past(st_r.wbyte))))
		else $error("writing zero changed a flag");

endmodule

// ==== tb/gup_pin_model.sv ====
// Pad model: LEDs on driven pins, pulled-up buttons on released ones.
// Assumes button levels come from the bench, synchronous to aclk.
`timescale 1ns/1ps
module gup_pin_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] btn,
	output logic      [7:0] pin_in
);
	// ==========================================================
	// Pad resolution
	// A driven pad shows the port's value, else the button
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : btn[i];
		end
	end
endmodule

// ==== tb/gup_utility_port_bench.sv ====
// Self-checking bench for the utility port: register rows, then change
// flags, pin muxing, auto-toggle and reset values.
// Assumes the pin model on the pads and a toggle half period of 4.
`timescale 1ns/1ps
module gup_utility_port_bench import gup_pkg::*;;
	typedef struct {
		logic [9:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic [1:0] r;
	} gup_row_t;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, strobe, tx, rx, t0, t1, irq, code, data;
	logic [9:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [7:0]  pin_in, pin_out, pin_oe, btn;
	int          mismatches, n_checks;
	// ==========================================================
	// Rows: address, write data, read-back, response
	gup_row_t rows [7] = '{
		'{10'h25C, 8'hF0, 8'hF0, RESP_OKAY},
		'{10'h268, 8'hA5, 8'hA5, RESP_OKAY},
		'{10'h270, 8'h3C, 8'h3C, RESP_OKAY},
		'{10'h274, 8'h00, 8'h00, RESP_OKAY},
		'{10'h26C, 8'h77, 8'hAC, RESP_OKAY},
		'{10'h3FC, 8'h11, 8'h00, RESP_SLVERR},
		'{10'h25D, 8'h22, 8'h00, RESP_SLVERR}};

	gup_utility_port #(.ADDR_W(10), .HALF_CYCLES(4)) i_gup_utility_port (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.disk_io_write_strobe(strobe), .processor_port3_bit1(tx),
		.processor_port3_bit0(rx), .timer0_trigger(t0), .timer1_trigger(t1),
		.processor_ext_irq_line(irq), .scratch_in_code_space(code),
		.scratch_in_data_space(data));
	gup_pin_model i_gup_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .btn(btn),
		.pin_in(pin_in));

	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (awready && !aw) begin
				aw = 1;
				awvalid <= 0;
			end
			if (wready && !w) begin
				w = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 0;
		chk(bresp, r);
		tick(1);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 0;
		chk(rdata, {24'h0, e});
		chk(rresp, r);
		tick(1);
	endtask
	task automatic rst();
		aresetn <= 0;
		tick(16);
		aresetn <= 1;
		tick(2);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		int hi, tr;
		logic prev;
		{awvalid, wvalid, bready, arvalid, rready} = 0;
		{awaddr, araddr, wdata} = 0;
		aresetn = 0;
		btn = 8'h5C;
		strobe = 1;
		tx = 1;
		mismatches = 0;
		n_checks = 0;
		@(posedge aclk);
		rst();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		chk({pin_oe, pin_out[7:4]}, 12'hF0A);
		// Setup writes keep bit 6 clear
		wr(10'h300, 8'hFF, RESP_OKAY);
		wr(10'h270, 8'hFE, RESP_OKAY);
		rd(10'h300, 8'h00, RESP_OKAY);
		chk(irq, 0);
		btn <= btn ^ 8'h01;
		tick(3);
		chk(irq, 1);
		rd(10'h300, 8'h01, RESP_OKAY);
		btn <= btn ^ 8'h01;
		tick(3);
		wr(10'h300, 8'h00, RESP_OKAY);
		rd(10'h300, 8'h01, RESP_OKAY);
		wr(10'h300, 8'h01, RESP_OKAY);
		rd(10'h300, 8'h00, RESP_OKAY);
		chk(irq, 0);
		btn <= btn ^ 8'h02;
		tick(3);
		chk(irq, 0);
		rd(10'h300, 8'h02, RESP_OKAY);
		// Pin muxing: all routes on, then all off
		btn <= 8'h5D;
		wr(10'h274, 8'h1F, RESP_OKAY);
		tick(3);
		chk({pin_out[4], pin_oe[4], pin_out[1], t0, t1, rx}, 6'b111000);
		// Drop both routed sources so a tied-high pin cannot pass
		strobe <= 0;
		tx <= 0;
		tick(3);
		chk({pin_out[4], pin_oe[4], pin_out[1], pin_oe[1]}, 4'b0101);
		wr(10'h274, 8'h00, RESP_OKAY);
		tick(3);
		chk({pin_out[4], pin_oe[1], t0, t1, rx}, 5'b00111);
		wr(10'h274, 8'h80, RESP_OKAY);
		tick(3);
		chk({code, data}, 2'b10);
		wr(10'h274, 8'h00, RESP_OKAY);
		tick(3);
		chk({code, data}, 2'b01);
		// Auto-toggle: 17 samples span two full periods of 8 cycles
		wr(10'h25C, 8'hF1, RESP_OKAY);
		wr(10'h274, 8'h20, RESP_OKAY);
		tick(3);
		hi = 0;
		tr = 0;
		prev = pin_out[0];
		repeat (16) begin
			@(posedge aclk);
			hi += (pin_out[0] === 1'b1);
			tr += (pin_out[0] !== prev);
			prev = pin_out[0];
		end
		chk(hi, 8);
		chk(tr, 4);
		wr(10'h274, 8'h00, RESP_OKAY);
		tick(3);
		chk(pin_out[0], 1);
		// Reset in mid-run restores every stored register
		rst();
		chk({pin_oe, irq}, 9'h000);
		chk({code, data}, 2'b01);
		rd(10'h25C, RST_PIN_DIRECTION, RESP_OKAY);
		rd(10'h268, RST_PIN_OUTPUT_DATA, RESP_OKAY);
		rd(10'h26C, 8'h5D, RESP_OKAY);
		rd(10'h270, RST_PIN_CHANGE_MASK, RESP_OKAY);
		rd(10'h274, RST_UTILITY_SETUP, RESP_OKAY);
		rd(10'h300, RST_PIN_CHANGE_FLAGS, RESP_OKAY);
		complete_run();
	end
	// ==========================================================
	// Watchdog: the whole run needs well under 2000 cycles
	initial begin
		tick(20000);
		mismatches++;
		complete_run();
	end
endmodule
